/* File: design/hcc_clk_nco.sv */
`timescale 1ns/100ps
`include "hcc_defines.svh"
module hcc_clk_nco (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // control
   input  wire logic                 drive_en,
   input  wire hcc_pkg::hcc_rate_type rate,
   // generated clock
   output logic                      clk_out
);

   logic [`HCC_NCO_W-1:0] acc_q;
   logic [`HCC_NCO_W-1:0] inc;

   always_comb begin
      case (rate)
         hcc_pkg::HCC_RATE_2M048:
            inc = `HCC_NCO_W'(`HCC_NCO_INC(`HCC_RATE0_HZ));
         hcc_pkg::HCC_RATE_4M096:
            inc = `HCC_NCO_W'(`HCC_NCO_INC(`HCC_RATE1_HZ));
         hcc_pkg::HCC_RATE_8M192:
            inc = `HCC_NCO_W'(`HCC_NCO_INC(`HCC_RATE2_HZ));
         default:
            inc = `HCC_NCO_W'(`HCC_NCO_INC(`HCC_RATE3_HZ));
      endcase
   end

   // phase accumulator, cleared to zero while the pin is an input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q   <= '0;
         clk_out <= 1'b0;
      end else if (!drive_en) begin
         acc_q   <= '0;
         clk_out <= 1'b0;
      end else begin
         acc_q   <= acc_q + inc;
         clk_out <= acc_q[`HCC_NCO_W-1];
      end
   end

endmodule : hcc_clk_nco

/* File: design/hcc_defines.svh */
`ifndef HCC_DEFINES_SVH
`define HCC_DEFINES_SVH

// register offsets
`define HCC_ADDR_LINE_CLOCK_PIN   16'hD08A
`define HCC_ADDR_LCLK1   16'hD08B
`define HCC_ADDR_LCLK2   16'hD08C
`define HCC_ADDR_CMD0    16'hD0CA
`define HCC_ADDR_CMD1    16'hD0CC
`define HCC_ADDR_CMD2    16'hD0CE
`define HCC_ADDR_CMD3    16'hD0D0
`define HCC_ADDR_ASYNC   16'hD0D2

// reset values
`define HCC_RST16        16'h0000
`define HCC_RST8         8'h00
`define HCC_RST5         5'h00
`define HCC_RST2         2'h0
`define HCC_RST20        20'h00000
`define HCC_RST4         4'h0
`define HCC_RST3         3'h0

// command register fields
`define HCC_FILL_MSB     4
`define HCC_FILL_LSB     0
`define HCC_GO_BIT       5
`define HCC_EOM_BIT      6

// line clock register fields
`define HCC_LCK_EN_BIT   2
`define HCC_RATE_MSB     1
`define HCC_RATE_LSB     0

// async port layout
`define HCC_PORT_W       8
`define HCC_RTS_BASE     4
`define HCC_MODE_ASYNC   2'h2

// clock generation
`define HCC_CLK_HZ       64'd10000000
`define HCC_NCO_W        24
`define HCC_NCO_SPAN     64'd16777216
`define HCC_RATE0_HZ     64'd2048000
`define HCC_RATE1_HZ     64'd4096000
`define HCC_RATE2_HZ     64'd8192000
`define HCC_RATE3_HZ     64'd16384000
`define HCC_NCO_INC(f)   ((f) * `HCC_NCO_SPAN / `HCC_CLK_HZ)

`endif

/* File: design/hcc_pkg.sv */
package hcc_pkg;

   typedef enum logic [1:0] {
      HCC_OP_HDLC  = 2'h0,
      HCC_OP_EXT   = 2'h1,
      HCC_OP_ASYNC = 2'h2,
      HCC_OP_RSVD  = 2'h3
   } hcc_op_mode_type;

   typedef enum logic [1:0] {
      HCC_RATE_2M048  = 2'h0,
      HCC_RATE_4M096  = 2'h1,
      HCC_RATE_8M192  = 2'h2,
      HCC_RATE_16M384 = 2'h3
   } hcc_rate_type;

endpackage : hcc_pkg

/* File: design/hcc_regs.sv */
// Function
// - go bit written one starts channel transmission; zero starts nothing
// - end-of-message bit set closes frame in this buffer; clear continues
// - four write-only command registers, reset zero, bits 15:7 unused
// - async port write drives tx data bits 0-3, rts bits 4-7
// - async port read returns live rx data bits 0-3, cts bits 4-7
// - async port bits act only while their channel is in async mode
// - channels 1-3 port bits need their pin-sharing select set
// - line clock bit 2 zero makes pin input, one drives clock
// - rate field 1:0 picks 2.048, 4.096, 8.192 or 16.384 MHz; off the 10 MHz clock codes 2 and 3 alias to about 1.808 and 3.616 MHz
// - rate field only matters while the line clock is driven
// - line clock register bits 15:3 read as zero
`timescale 1ns/100ps
`include "hcc_defines.svh"
module hcc_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // channel configuration from mode and pin-sharing registers
   input  wire logic [7:0]  channel_op_mode,
   input  wire logic [2:0]  pin_share_select,
   // transmit command outputs to the framer
   output logic      [19:0] tx_fill_count,
   output logic      [3:0]  tx_go,
   output logic      [3:0]  tx_end_of_msg,
   // async line pins
   input  wire logic [3:0]  line_rx_data_pin,
   input  wire logic [3:0]  line_clear_to_send,
   output logic      [3:0]  line_tx_data_pin,
   output logic      [3:0]  line_request_to_send,
   // line clock pins
   input  wire logic [2:0]  line_clock_pin_i,
   output logic      [2:0]  line_clock_pin_o,
   output logic      [2:0]  line_clock_drive_en,
   output logic      [2:0]  line_clock_rise
);

   // register state
   logic [2:0]  lck_en_q;
   logic [1:0]  lck_rate_q [3];
   logic [`HCC_PORT_W-1:0] port_q;

   // synchronised pins and generated line clocks
   logic [`HCC_PORT_W-1:0] pin_in_s;
   logic [2:0]  lck_in_s;
   logic [2:0]  lck_in_prev_q;
   logic [2:0]  nco_out;

   // decode
   logic [3:0]  cmd_hit;
   logic [2:0]  lck_hit;
   logic        port_hit;
   logic [3:0]  chan_open;
   logic [`HCC_PORT_W-1:0] bit_open;
   logic [15:0] rdata_d;

   // input synchronisers
   hcc_sync2 #(
      .W (`HCC_PORT_W)
   ) u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({line_clear_to_send, line_rx_data_pin}),
      .sync_out (pin_in_s)
   );

   hcc_sync2 #(
      .W (3)
   ) u_lck_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (line_clock_pin_i),
      .sync_out (lck_in_s)
   );

   // address decode
   always_comb begin
      cmd_hit  = 4'h0;
      lck_hit  = 3'h0;
      port_hit = 1'b0;
      if (reg_addr == `HCC_ADDR_CMD0) begin
         cmd_hit[0] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_CMD1) begin
         cmd_hit[1] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_CMD2) begin
         cmd_hit[2] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_CMD3) begin
         cmd_hit[3] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_LINE_CLOCK_PIN) begin
         lck_hit[0] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_LCLK1) begin
         lck_hit[1] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_LCLK2) begin
         lck_hit[2] = 1'b1;
      end else if (reg_addr == `HCC_ADDR_ASYNC) begin
         port_hit = 1'b1;
      end
   end

   // which channels may touch the async port
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         chan_open[c] = (channel_op_mode[2*c +: 2] == `HCC_MODE_ASYNC);
      end
      chan_open[3:1] = chan_open[3:1] & pin_share_select;
      bit_open = {chan_open, chan_open};
   end

   // transmit command registers, one per channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_fill_count <= `HCC_RST20;
         tx_end_of_msg <= `HCC_RST4;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (reg_wr && cmd_hit[c]) begin
               tx_fill_count[5*c +: 5] <=
                  reg_wdata[`HCC_FILL_MSB:`HCC_FILL_LSB];
               tx_end_of_msg[c] <= reg_wdata[`HCC_EOM_BIT];
            end
         end
      end
   end

   // start pulse, one cycle after the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_go <= `HCC_RST4;
      end else begin
         for (int c = 0; c < 4; c++) begin
            tx_go[c] <= reg_wr && cmd_hit[c] && reg_wdata[`HCC_GO_BIT];
         end
      end
   end

   // line clock control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lck_en_q <= `HCC_RST3;
         for (int k = 0; k < 3; k++) begin
            lck_rate_q[k] <= `HCC_RST2;
         end
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (reg_wr && lck_hit[k]) begin
               lck_en_q[k]   <= reg_wdata[`HCC_LCK_EN_BIT];
               lck_rate_q[k] <=
                  reg_wdata[`HCC_RATE_MSB:`HCC_RATE_LSB];
            end
         end
      end
   end

   // async port output latch, per-bit gated
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_q <= `HCC_RST8;
      end else if (reg_wr && port_hit) begin
         port_q <= (reg_wdata[`HCC_PORT_W-1:0] & bit_open)
                 | (port_q & ~bit_open);
      end
   end

   // pins driven from the port latch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_tx_data_pin     <= `HCC_RST4;
         line_request_to_send <= `HCC_RST4;
      end else begin
         line_tx_data_pin     <= port_q[`HCC_RTS_BASE-1:0];
         line_request_to_send <= port_q[`HCC_PORT_W-1:`HCC_RTS_BASE];
      end
   end

   // generated line clocks
   for (genvar k = 0; k < 3; k++) begin : g_lck
      hcc_clk_nco u_nco (
         .clk      (clk),
         .rst_n    (rst_n),
         .drive_en (lck_en_q[k]),
         .rate     (hcc_pkg::hcc_rate_type'(lck_rate_q[k])),
         .clk_out  (nco_out[k])
      );
   end

   // pin drive and enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_clock_pin_o    <= `HCC_RST3;
         line_clock_drive_en <= `HCC_RST3;
      end else begin
         line_clock_pin_o    <= nco_out & lck_en_q;
         line_clock_drive_en <= lck_en_q;
      end
   end

   // rising edges of an external line clock, only while it is an input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lck_in_prev_q   <= `HCC_RST3;
         line_clock_rise <= `HCC_RST3;
      end else begin
         lck_in_prev_q   <= lck_in_s;
         line_clock_rise <= lck_in_s & ~lck_in_prev_q & ~lck_en_q;
      end
   end

   // read mux
   always_comb begin
      rdata_d = `HCC_RST16;
      if (port_hit) begin
         rdata_d[`HCC_PORT_W-1:0] = pin_in_s & bit_open;
      end else if (lck_hit[0]) begin
         rdata_d[`HCC_LCK_EN_BIT] = lck_en_q[0];
         rdata_d[`HCC_RATE_MSB:`HCC_RATE_LSB] = lck_rate_q[0];
      end else if (lck_hit[1]) begin
         rdata_d[`HCC_LCK_EN_BIT] = lck_en_q[1];
         rdata_d[`HCC_RATE_MSB:`HCC_RATE_LSB] = lck_rate_q[1];
      end else if (lck_hit[2]) begin
         rdata_d[`HCC_LCK_EN_BIT] = lck_en_q[2];
         rdata_d[`HCC_RATE_MSB:`HCC_RATE_LSB] = lck_rate_q[2];
      end
   end

   // read data stand for one cycle only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `HCC_RST16;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= `HCC_RST16;
      end
   end

endmodule : hcc_regs

/* File: design/hcc_sync2.sv */
`timescale 1ns/100ps
module hcc_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : hcc_sync2

/* File: tb/hcc_line_model.sv */
`timescale 1ns/100ps
module hcc_line_model (
   // control
   input wire logic       run,
   input wire logic [7:0] lvl,
   // device pins
   input wire logic [2:0] line_clock_drive_en,
   input wire logic [2:0] line_clock_pin_o,
   output logic     [3:0] line_rx_data_pin,
   output logic     [3:0] line_clear_to_send,
   output logic     [2:0] line_clock_pin_i
);
   logic ext;
   // link clock, 800 ns, still while run is low
   initial begin
      ext = 1'b0;
      forever #400 ext = run ? ~ext : 1'b0;
   end
   assign {line_clear_to_send, line_rx_data_pin} = lvl;
   assign line_clock_pin_i = (line_clock_drive_en & line_clock_pin_o)
                           | (~line_clock_drive_en & {3{ext}});
endmodule : hcc_line_model

/* File: tb/hcc_regs_sva.sv */
`timescale 1ns/100ps
`include "hcc_defines.svh"
module hcc_regs_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // configuration
   input wire logic [7:0]  channel_op_mode,
   input wire logic [2:0]  pin_share_select,
   // outputs
   input wire logic [19:0] tx_fill_count,
   input wire logic [3:0]  tx_go,
   input wire logic [3:0]  tx_end_of_msg,
   input wire logic [3:0]  line_tx_data_pin,
   input wire logic [3:0]  line_request_to_send,
   input wire logic [2:0]  line_clock_pin_o,
   input wire logic [2:0]  line_clock_drive_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_go;
      reg_wr && reg_addr == `HCC_ADDR_CMD0 && reg_wdata[5]
      |=> tx_go[0] && tx_fill_count[4:0] == $past(reg_wdata[4:0]);
   endproperty
   a_go: assert property (p_go) else $error("go");
   property p_nogo;
      tx_go[1] |-> $past(reg_wr && reg_addr == `HCC_ADDR_CMD1 && reg_wdata[5]);
   endproperty
   a_nogo: assert property (p_nogo) else $error("nogo");
   property p_eom;
      reg_wr && reg_addr == `HCC_ADDR_CMD3 |=> tx_end_of_msg[3] == $past(reg_wdata[6]);
   endproperty
   a_eom: assert property (p_eom) else $error("eom");
   property p_cmd_rd;
      reg_rd && reg_addr == `HCC_ADDR_CMD2 |=> reg_rdata == 16'h0000;
   endproperty
   a_cmd_rd: assert property (p_cmd_rd) else $error("cmd rd");
   property p_lck_rd;
      reg_rd && reg_addr == `HCC_ADDR_LCLK1 |=> reg_rdata[15:3] == 13'h0000;
   endproperty
   a_lck_rd: assert property (p_lck_rd) else $error("lck rd");
   property p_en;
      reg_wr && reg_addr == `HCC_ADDR_LCLK2
      |=> ##1 line_clock_drive_en[2] == $past(reg_wdata[2], 2);
   endproperty
   a_en: assert property (p_en) else $error("drive en");
   property p_off;
      !line_clock_drive_en[0] && $past(!line_clock_drive_en[0]) |-> !line_clock_pin_o[0];
   endproperty
   a_off: assert property (p_off) else $error("pin off");
   property p_tx;
      reg_wr && reg_addr == `HCC_ADDR_ASYNC && channel_op_mode[1:0] == 2'h2
      |=> ##1 line_tx_data_pin[0] == $past(reg_wdata[0], 2);
   endproperty
   a_tx: assert property (p_tx) else $error("txd");
   property p_keep;
      reg_wr && reg_addr == `HCC_ADDR_ASYNC && channel_op_mode[3:2] != 2'h2
      |=> ##1 $stable(line_request_to_send[1]);
   endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_sel;
      reg_rd && reg_addr == `HCC_ADDR_ASYNC && !pin_share_select[0]
      |=> !reg_rdata[1] && !reg_rdata[5];
   endproperty
   a_sel: assert property (p_sel) else $error("select");
endmodule : hcc_regs_sva
bind hcc_regs hcc_regs_sva u_sva (.*);

/* File: tb/test_hcc_regs.sv */
`timescale 1ns/100ps
`include "hcc_defines.svh"
module test_hcc_regs;
   logic        clk, rst_n, reg_wr, reg_rd, run;
   logic [15:0] reg_addr, reg_wdata, reg_rdata;
   logic [7:0]  channel_op_mode, lvl;
   logic [2:0]  pin_share_select, line_clock_pin_i, line_clock_pin_o;
   logic [2:0]  line_clock_drive_en, line_clock_rise;
   logic [19:0] tx_fill_count;
   logic [3:0]  tx_go, tx_end_of_msg, line_rx_data_pin, line_clear_to_send;
   logic [3:0]  line_tx_data_pin, line_request_to_send;
   int          miscompares, checks_done, n, m;
   hcc_regs DUT (.*);
   hcc_line_model u_line (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input string nm);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, {4'h0, reg_rdata}, {4'h0, e});
   endtask : rd
   task automatic count(input int k);
      logic p;
      p = line_clock_pin_o[0];
      n = 0;
      m = 0;
      repeat (k) begin
         cyc(1);
         n += int'(line_clock_pin_o[0] && !p);
         m += int'(line_clock_rise[0]);
         p = line_clock_pin_o[0];
      end
   endtask : count
   task automatic t_cmd;
      for (int c = 0; c < 4; c++) begin
         wr(`HCC_ADDR_CMD0 + 16'(2 * c), 16'h0060 | 16'(c + 5));
         chk("go", 20'(tx_go), 20'(1 << c));
         chk("fill", 20'(tx_fill_count[5*c +: 5]), 20'(c + 5));
         chk("eom", 20'(tx_end_of_msg[c]), 20'h1);
         cyc(1);
         chk("go_end", 20'(tx_go), 20'h0);
         rd(`HCC_ADDR_CMD0 + 16'(2 * c), 16'h0000, "cmd_rd");
      end
      wr(`HCC_ADDR_CMD1, 16'h001F);
      chk("nogo", 20'(tx_go), 20'h0);
      chk("eom_mix", 20'(tx_end_of_msg), 20'hD);
      chk("fill_mix", tx_fill_count, 20'h41FE5);
   endtask : t_cmd
   task automatic t_lclk;
      for (int i = 0; i < 3; i++) begin
         rd(`HCC_ADDR_LINE_CLOCK_PIN + 16'(i), 16'h0000, "lck_rst");
         wr(`HCC_ADDR_LINE_CLOCK_PIN + 16'(i), 16'hFFF8 | 16'(5 + i));
         cyc(1);
         chk("drv_en", 20'(line_clock_drive_en), 20'((2 << i) - 1));
         rd(`HCC_ADDR_LINE_CLOCK_PIN + 16'(i), 16'(5 + i), "lck_rd");
      end
      count(1000);
      chk("rate", 20'(n >= 408 && n <= 411), 20'h1);
      wr(`HCC_ADDR_LINE_CLOCK_PIN, 16'h0003);
      @(posedge clk);
      run <= 1'b1;
      cyc(2);
      count(400);
      chk("rate_off", 20'(n), 20'h0);
      chk("ext_rise", 20'(m >= 48 && m <= 52), 20'h1);
      run <= 1'b0;
   endtask : t_lclk
   task automatic t_async;
      @(posedge clk);
      channel_op_mode <= 8'hAA;
      pin_share_select <= 3'h7;
      lvl <= 8'h5A;
      wr(`HCC_ADDR_ASYNC, 16'hFFC3);
      cyc(1);
      chk("txd", 20'(line_tx_data_pin), 20'h3);
      chk("rts", 20'(line_request_to_send), 20'hC);
      rd(`HCC_ADDR_ASYNC, 16'h005A, "port_rd");
      @(posedge clk);
      channel_op_mode <= 8'hA2;
      pin_share_select <= 3'h3;
      wr(`HCC_ADDR_ASYNC, 16'h0000);
      cyc(1);
      chk("txd_keep", 20'(line_tx_data_pin), 20'h2);
      chk("rts_keep", 20'(line_request_to_send), 20'h8);
      rd(`HCC_ADDR_ASYNC, 16'h0050, "port_mask");
   endtask : t_async
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      {rst_n, reg_wr, reg_rd, run, reg_addr, reg_wdata} = '0;
      {channel_op_mode, pin_share_select, lvl} = '0;
      miscompares = 0;
      checks_done = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      chk("rst_out", {tx_go, tx_end_of_msg, 12'h000}, 20'h0);
      rd(`HCC_ADDR_ASYNC, 16'h0000, "async_rst");
      t_cmd;
      t_lclk;
      t_async;
      tally_and_finish;
   end
   initial begin
      #5000000;
      miscompares++;
      tally_and_finish;
   end
endmodule : test_hcc_regs
